// ==== fqd_defs.svh ====
// Constants for the flash command host: timing, register map, commands.
// Assumes a 10 MHz system clock and a x16 flash with a 20-bit word address.
`ifndef FQD_DEFS_SVH
`define FQD_DEFS_SVH

// Clock rate and flash bus timing in nanoseconds
`define FQD_CLK_MHZ      10
`define FQD_T_SETUP_NS   30
`define FQD_T_WP_NS      35
`define FQD_T_ACC_NS     70
`define FQD_T_REC_NS     20
// Least times round up to whole cycles
`define FQD_NS2CYC(ns)   ((((ns) * `FQD_CLK_MHZ) + 999) / 1000)
`define FQD_CYC_SETUP    `FQD_NS2CYC(`FQD_T_SETUP_NS)
`define FQD_CYC_WP       `FQD_NS2CYC(`FQD_T_WP_NS)
`define FQD_CYC_ACC      `FQD_NS2CYC(`FQD_T_ACC_NS)
`define FQD_CYC_REC      `FQD_NS2CYC(`FQD_T_REC_NS)
`define FQD_SYNC_LAG     2

// Software register byte offsets
`define FQD_REG_CTRL     8'h00
`define FQD_REG_ADDR     8'h04
`define FQD_REG_WDATA    8'h08
`define FQD_REG_STATUS   8'h0C
`define FQD_REG_QMASK    8'h10
`define FQD_RES_BIT      7

// Status bit positions
`define FQD_ST_BUSY      0
`define FQD_ST_DONE      1
`define FQD_ST_QRY_OK    2
`define FQD_ST_TMO       3
`define FQD_ST_ABT       4
`define FQD_ST_AUTOSEL   5
`define FQD_ST_QUERY     6
`define FQD_ST_SUSP      7

// Operation codes of CTRL[3:0]; a write starts codes 1 to 7, codes 8 and 9 are loaded only by the sequencer
`define FQD_OP_NOP       4'h0
`define FQD_OP_RESET     4'h1
`define FQD_OP_READ      4'h2
`define FQD_OP_PROGRAM   4'h3
`define FQD_OP_AUTOSEL   4'h4
`define FQD_OP_QUERY     4'h5
`define FQD_OP_SUSPEND   4'h6
`define FQD_OP_RESUME    4'h7
`define FQD_OP_RCV_RST   4'h8
`define FQD_OP_RCV_ABT   4'h9

// Flash command addresses and data
`define FQD_UNLK_A1      20'h0_0555
`define FQD_UNLK_A2      20'h0_02AA
`define FQD_QRY_A        20'h0_0055
`define FQD_ANY_A        20'h0_0000
`define FQD_CMD_UNLK1    16'h00AA
`define FQD_CMD_UNLK2    16'h0055
`define FQD_CMD_AUTOSEL  16'h0090
`define FQD_CMD_QUERY    16'h0098
`define FQD_CMD_RESET    16'h00F0
`define FQD_CMD_PROG     16'h00A0
`define FQD_CMD_SUSP     16'h00B0
`define FQD_CMD_RESUME   16'h0030

// Identifier locations
`define FQD_ID_MFR       20'h0_0000
`define FQD_ID_DEV1      20'h0_0001
`define FQD_ID_DEV2      20'h0_000E
`define FQD_ID_DEV3      20'h0_000F
`define FQD_ID_SECSI     20'h0_0003
`define FQD_ID_PROT_LO   8'h02

// Extended query table: base, length and expected words
`define FQD_QRY_BASE     20'h0_0040
`define FQD_QRY_LEN      17
`define FQD_QV_P         16'h0050
`define FQD_QV_R         16'h0052
`define FQD_QV_I         16'h0049
`define FQD_QV_MAJOR     16'h0031
`define FQD_QV_MINOR     16'h0033
`define FQD_QV_ESUSP     16'h0002
`define FQD_QV_PROTGRP   16'h0001
`define FQD_QV_TMPUNP    16'h0001
`define FQD_QV_SCHEME    16'h0004
`define FQD_QV_SIMUL     16'h0000
`define FQD_QV_BURST     16'h0000
`define FQD_QV_PAGE      16'h0001
`define FQD_QV_ACCMIN    16'h00B5
`define FQD_QV_ACCMAX    16'h00C5
`define FQD_QV_BOOTLO    8'h02
`define FQD_QV_BOOTHI    8'h05
`define FQD_QV_PSUSP     16'h0001

`endif

// ==== fqd_pkg.sv ====
// Types shared by the flash command host and its bus cycle engine.
// Assumes fqd_defs.svh supplies all numeric constants.
package fqd_pkg;

	// Sequencer states
	typedef enum logic [1:0] {Q_IDLE, Q_ISSUE, Q_WAIT} fqd_seq_state_t;

	// Bus cycle engine states
	typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_READ, C_SAMP, C_RECOV} fqd_cyc_state_t;

	// Kind of one step in a command sequence
	typedef enum logic [1:0] {K_END, K_WRITE, K_READ, K_POLL} fqd_kind_t;

	// One step: kind, command flag, word address, data
	typedef struct packed {
		fqd_kind_t   kind;
		logic        cmd;
		logic [19:0] addr;
		logic [15:0] data;
	} fqd_step_t;

endpackage

// ==== fqd_cycle_if.sv ====
// Request/answer bundle between the sequencer and the flash bus cycle engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface fqd_cycle_if;
	logic        req;
	logic        wr;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;

	modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ==== fqd_bus_cycle.sv ====
// One asynchronous flash bus cycle (write or read) on the flash pins.
// Assumes the sequencer only raises req while this engine is idle.
`timescale 1ns/10ps
`default_nettype none
`include "fqd_defs.svh"
module fqd_bus_cycle (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Sequencer side
	fqd_cycle_if.eng         cyc,
	// Flash pins
	output logic [19:0]      fl_addr,
	output logic [15:0]      fl_dq_o,
	output logic             fl_dq_oe_n,
	input  wire logic [15:0] fl_dq_i,
	output logic             fl_ce_n,
	output logic             fl_we_n,
	output logic             fl_oe_n
);

	fqd_pkg::fqd_cyc_state_t state_r;
	logic [3:0]              cnt_r;
	logic                    wr_r;
	logic [15:0]             dq_s1_r;
	logic [15:0]             dq_s2_r;
	logic [15:0]             dq_s3_r;
	logic [15:0]             rdata_r;
	logic                    dq_stable;

	// Pin data passes three flops; it counts once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dq_s1_r <= 16'h0000;
			dq_s2_r <= 16'h0000;
			dq_s3_r <= 16'h0000;
		end
		else
		begin
			dq_s1_r <= fl_dq_i;
			dq_s2_r <= dq_s1_r;
			dq_s3_r <= dq_s2_r;
		end
	end
	assign dq_stable = (dq_s2_r == dq_s3_r);

	// Cycle sequencing
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= fqd_pkg::C_IDLE;
			cnt_r   <= 4'h0;
			wr_r    <= 1'b0;
		end
		else
		begin
			case (state_r)
				fqd_pkg::C_IDLE:
				if (cyc.req)
				begin
					state_r <= fqd_pkg::C_SETUP;
					cnt_r   <= 4'(`FQD_CYC_SETUP - 1);
					wr_r    <= cyc.wr;
				end
				fqd_pkg::C_SETUP:
				if (cnt_r != 4'h0)
					cnt_r <= cnt_r - 4'h1;
				else if (wr_r)
				begin
					state_r <= fqd_pkg::C_STROBE;
					cnt_r   <= 4'(`FQD_CYC_WP - 1);
				end
				else
				begin
					// Extra cycles let the pin data reach the last sync stage
					state_r <= fqd_pkg::C_READ;
					cnt_r   <= 4'(`FQD_CYC_ACC + `FQD_SYNC_LAG);
				end
				fqd_pkg::C_STROBE:
				if (cnt_r != 4'h0)
					cnt_r <= cnt_r - 4'h1;
				else
					state_r <= fqd_pkg::C_HOLD;
				fqd_pkg::C_READ:
				if (cnt_r != 4'h0)
					cnt_r <= cnt_r - 4'h1;
				else
					state_r <= fqd_pkg::C_SAMP;
				fqd_pkg::C_HOLD:
				begin
					state_r <= fqd_pkg::C_RECOV;
					cnt_r   <= 4'(`FQD_CYC_REC - 1);
				end
				fqd_pkg::C_SAMP:
				if (dq_stable)
				begin
					state_r <= fqd_pkg::C_RECOV;
					cnt_r   <= 4'(`FQD_CYC_REC - 1);
				end
				fqd_pkg::C_RECOV:
				if (cnt_r != 4'h0)
					cnt_r <= cnt_r - 4'h1;
				else
					state_r <= fqd_pkg::C_IDLE;
				default:
					state_r <= fqd_pkg::C_IDLE;
			endcase
		end
	end

	// Pin drive; CE falls before WE and WE rises before CE, so the device
	// latches address on the WE fall and data on the WE rise
	// strobe edge order
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fl_addr    <= 20'h0_0000;
			fl_dq_o    <= 16'h0000;
			fl_dq_oe_n <= 1'b1;
			fl_ce_n    <= 1'b1;
			fl_we_n    <= 1'b1;
			fl_oe_n    <= 1'b1;
			rdata_r    <= 16'h0000;
		end
		else if (state_r == fqd_pkg::C_IDLE && cyc.req)
		begin
			fl_addr    <= cyc.addr;
			fl_dq_o    <= cyc.wdata;
			fl_dq_oe_n <= ~cyc.wr;      // Drive data only on writes
			fl_ce_n    <= 1'b0;
		end
		else if (state_r == fqd_pkg::C_SETUP && cnt_r == 4'h0)
		begin
			fl_we_n <= ~wr_r;
			fl_oe_n <= wr_r;
		end
		else if (state_r == fqd_pkg::C_STROBE && cnt_r == 4'h0)
			fl_we_n <= 1'b1;
		else if (state_r == fqd_pkg::C_HOLD)
		begin
			// Data released on the same edge as the CE rise
			fl_ce_n    <= 1'b1;
			fl_dq_oe_n <= 1'b1;
		end
		else if (state_r == fqd_pkg::C_SAMP && dq_stable)
		begin
			rdata_r <= dq_s3_r;
			fl_oe_n <= 1'b1;
			fl_ce_n <= 1'b1;
		end
	end

	// One-cycle completion at the end of recovery
	assign cyc.done  = (state_r == fqd_pkg::C_RECOV) && (cnt_r == 4'h0);
	assign cyc.rdata = rdata_r;

endmodule
`default_nettype wire

// ==== fqd_host_ctrl.sv ====
// Host controller that drives a page-mode NOR flash over its parallel pins:
// resets, array reads, word program with polling, erase suspend/resume,
// identifier reads and an extended query table check.
// Assumes a register master with one-cycle strobes and a flash on the pins.
`timescale 1ns/10ps
`default_nettype none
`include "fqd_defs.svh"
module fqd_host_ctrl (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [31:0]      REG_RDATA,
	// Flash pins
	output logic [19:0]      FL_ADDR,
	output logic [15:0]      FL_DQ_O,
	output logic             FL_DQ_OE_N,
	input  wire logic [15:0] FL_DQ_I,
	output logic             FL_CE_N,
	output logic             FL_WE_N,
	output logic             FL_OE_N
);

	fqd_cycle_if cyc ();

	fqd_pkg::fqd_seq_state_t seq_r;
	fqd_pkg::fqd_step_t      step;
	logic [3:0]              op_r;
	logic [4:0]              idx_r;
	logic [19:0]             addr_r;
	logic [15:0]             wdata_r;
	logic                    retry_r;
	logic                    done_r;
	logic                    tmo_r;
	logic                    abt_r;
	logic                    autosel_r;
	logic                    query_r;
	logic                    susp_r;
	logic [16:0]             qmask_r;
	logic [15:0]             res_mem [0:31];
	logic                    busy;
	logic                    start;
	logic                    cyc_end;
	logic                    poll_eval;
	logic                    poll_hit;
	logic                    abt_hit;
	logic                    tmo_hit;
	logic                    cmd_done;
	logic [4:0]              qidx;

	// Build one sequence step
	function automatic fqd_pkg::fqd_step_t mk(input fqd_pkg::fqd_kind_t k, input logic c,
		input logic [19:0] a, input logic [15:0] d);
		fqd_pkg::fqd_step_t s;
		s.kind = k;
		s.cmd  = c;
		s.addr = a;
		s.data = d;
		return s;
	endfunction

	// Step table of every operation; anything past the end is K_END
	function automatic fqd_pkg::fqd_step_t step_of(input logic [3:0] op, input logic [4:0] i,
		input logic [19:0] a, input logic [15:0] d);
		fqd_pkg::fqd_step_t s;
		s = mk(fqd_pkg::K_END, 1'b0, `FQD_ANY_A, 16'h0000);
		case (op)
			`FQD_OP_RESET, `FQD_OP_RCV_RST:
				if (i == 5'h00) s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_ANY_A, `FQD_CMD_RESET);
			`FQD_OP_READ:
				if (i == 5'h00) s = mk(fqd_pkg::K_READ, 1'b0, a, 16'h0000);
			`FQD_OP_PROGRAM:
				case (i)
					5'h00: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A1, `FQD_CMD_UNLK1);
					5'h01: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A2, `FQD_CMD_UNLK2);
					5'h02: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A1, `FQD_CMD_PROG);
					5'h03: s = mk(fqd_pkg::K_WRITE, 1'b0, a, d);
					5'h04: s = mk(fqd_pkg::K_POLL, 1'b0, a, 16'h0000);
					default: s = mk(fqd_pkg::K_END, 1'b0, `FQD_ANY_A, 16'h0000);
				endcase
			`FQD_OP_AUTOSEL:
				case (i)
					5'h00: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A1, `FQD_CMD_UNLK1);
					5'h01: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A2, `FQD_CMD_UNLK2);
					5'h02: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A1, `FQD_CMD_AUTOSEL);
					5'h03: s = mk(fqd_pkg::K_READ, 1'b0, `FQD_ID_MFR, 16'h0000);
					5'h04: s = mk(fqd_pkg::K_READ, 1'b0, `FQD_ID_DEV1, 16'h0000);
					5'h05: s = mk(fqd_pkg::K_READ, 1'b0, `FQD_ID_DEV2, 16'h0000);
					5'h06: s = mk(fqd_pkg::K_READ, 1'b0, `FQD_ID_DEV3, 16'h0000);
					5'h07: s = mk(fqd_pkg::K_READ, 1'b0, `FQD_ID_SECSI, 16'h0000);
					5'h08: s = mk(fqd_pkg::K_READ, 1'b0, {a[19:8], `FQD_ID_PROT_LO}, 16'h0000);
					5'h09: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_ANY_A, `FQD_CMD_RESET);
					default: s = mk(fqd_pkg::K_END, 1'b0, `FQD_ANY_A, 16'h0000);
				endcase
			`FQD_OP_QUERY:
				if (i == 5'h00)
					s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_QRY_A, `FQD_CMD_QUERY);
				else if (i <= 5'(`FQD_QRY_LEN))
					s = mk(fqd_pkg::K_READ, 1'b0, `FQD_QRY_BASE + 20'(i - 5'h01), 16'h0000);
				else if (i == 5'(`FQD_QRY_LEN + 1))
					s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_ANY_A, `FQD_CMD_RESET);
			`FQD_OP_SUSPEND:
				if (i == 5'h00) s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_ANY_A, `FQD_CMD_SUSP);
			`FQD_OP_RESUME:
				if (i == 5'h00) s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_ANY_A, `FQD_CMD_RESUME);
			`FQD_OP_RCV_ABT:
				case (i)
					5'h00: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A1, `FQD_CMD_UNLK1);
					5'h01: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A2, `FQD_CMD_UNLK2);
					5'h02: s = mk(fqd_pkg::K_WRITE, 1'b1, `FQD_UNLK_A1, `FQD_CMD_RESET);
					default: s = mk(fqd_pkg::K_END, 1'b0, `FQD_ANY_A, 16'h0000);
				endcase
			default:
				s = mk(fqd_pkg::K_END, 1'b0, `FQD_ANY_A, 16'h0000);
		endcase
		return s;
	endfunction

	// Check one extended query word against its expected value
	function automatic logic q_ok(input logic [4:0] qi, input logic [15:0] v);
		logic ok;
		ok = 1'b0;
		// words must match in all 16 bits, except words 05h and 0Fh, which are checked by field
		case (qi)
			5'h00: ok = (v == `FQD_QV_P);
			5'h01: ok = (v == `FQD_QV_R);
			5'h02: ok = (v == `FQD_QV_I);
			5'h03: ok = (v == `FQD_QV_MAJOR);
			5'h04: ok = (v == `FQD_QV_MINOR);
			// unlock field is 0 or 1, process code free
			5'h05: ok = (v[15:8] == 8'h00) && !v[1];
			5'h06: ok = (v == `FQD_QV_ESUSP);
			5'h07: ok = (v == `FQD_QV_PROTGRP);
			5'h08: ok = (v == `FQD_QV_TMPUNP);
			5'h09: ok = (v == `FQD_QV_SCHEME);
			5'h0A: ok = (v == `FQD_QV_SIMUL);
			5'h0B: ok = (v == `FQD_QV_BURST);
			5'h0C: ok = (v == `FQD_QV_PAGE);
			5'h0D: ok = (v == `FQD_QV_ACCMIN);
			5'h0E: ok = (v == `FQD_QV_ACCMAX);
			5'h0F: ok = (v[15:8] == 8'h00) && (v[7:0] >= `FQD_QV_BOOTLO) && (v[7:0] <= `FQD_QV_BOOTHI);
			5'h10: ok = (v == `FQD_QV_PSUSP);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Current step and request to the cycle engine
	assign step      = step_of(op_r, idx_r, addr_r, wdata_r);
	assign cyc.req   = (seq_r == fqd_pkg::Q_ISSUE) && (step.kind != fqd_pkg::K_END);
	assign cyc.wr    = (step.kind == fqd_pkg::K_WRITE);
	assign cyc.addr  = step.addr;
	assign cyc.wdata = step.data;

	// Events of the sequencer
	assign busy      = (seq_r != fqd_pkg::Q_IDLE);
	assign start     = REG_WR && (REG_ADDR == `FQD_REG_CTRL) && !busy && (REG_WDATA[3:0] != `FQD_OP_NOP)
		&& (REG_WDATA[3:0] <= `FQD_OP_RESUME);
	assign cyc_end   = (seq_r == fqd_pkg::Q_WAIT) && cyc.done;
	assign poll_eval = cyc_end && (step.kind == fqd_pkg::K_POLL);
	assign poll_hit  = (cyc.rdata[7] == wdata_r[7]);
	assign abt_hit   = poll_eval && !poll_hit && cyc.rdata[1];
	assign tmo_hit   = poll_eval && !poll_hit && !cyc.rdata[1] && cyc.rdata[5] && retry_r;
	assign cmd_done  = cyc_end && (step.kind == fqd_pkg::K_WRITE) && step.cmd;
	assign qidx      = idx_r - 5'h01;

	// Instance of the flash bus cycle engine
	fqd_bus_cycle u_cycle (
		.clk        (SYS_CLK),
		.rst        (RESET),
		.cyc        (cyc.eng),
		.fl_addr    (FL_ADDR),
		.fl_dq_o    (FL_DQ_O),
		.fl_dq_oe_n (FL_DQ_OE_N),
		.fl_dq_i    (FL_DQ_I),
		.fl_ce_n    (FL_CE_N),
		.fl_we_n    (FL_WE_N),
		.fl_oe_n    (FL_OE_N)
	);

	// Sequencer: walk the step table, poll a program to its end
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			seq_r   <= fqd_pkg::Q_IDLE;
			op_r    <= `FQD_OP_NOP;
			idx_r   <= 5'h00;
			retry_r <= 1'b0;
		end
		else
		begin
			case (seq_r)
				fqd_pkg::Q_IDLE:
				if (start)
				begin
					op_r    <= REG_WDATA[3:0];
					idx_r   <= 5'h00;
					retry_r <= 1'b0;
					seq_r   <= fqd_pkg::Q_ISSUE;
				end
				fqd_pkg::Q_ISSUE:
					seq_r <= (step.kind == fqd_pkg::K_END) ? fqd_pkg::Q_IDLE : fqd_pkg::Q_WAIT;
				fqd_pkg::Q_WAIT:
				if (cyc.done)
				begin
					seq_r <= fqd_pkg::Q_ISSUE;
					if (step.kind != fqd_pkg::K_POLL || poll_hit)
						idx_r <= idx_r + 5'h01;
					// abort flag needs the abort reset
					else if (cyc.rdata[1])
					begin
						op_r  <= `FQD_OP_RCV_ABT;
						idx_r <= 5'h00;
					end
					else if (cyc.rdata[5] && retry_r)
					begin
						op_r  <= `FQD_OP_RCV_RST;
						idx_r <= 5'h00;
					end
					else if (cyc.rdata[5])
						retry_r <= 1'b1;   // Reread once: flag and data may change together
				end
				default:
					seq_r <= fqd_pkg::Q_IDLE;
			endcase
		end
	end

	// Sticky result flags, cleared by the next start
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			done_r <= 1'b0;
			tmo_r  <= 1'b0;
			abt_r  <= 1'b0;
		end
		else if (start)
		begin
			done_r <= 1'b0;
			tmo_r  <= 1'b0;
			abt_r  <= 1'b0;
		end
		else
		begin
			done_r <= done_r | ((seq_r == fqd_pkg::Q_ISSUE) && (step.kind == fqd_pkg::K_END));
			tmo_r  <= tmo_r | tmo_hit;
			abt_r  <= abt_r | abt_hit;
		end
	end

	// Track the mode the flash is in; a reset keeps an erase suspended
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			autosel_r <= 1'b0;
			query_r   <= 1'b0;
			susp_r    <= 1'b0;
		end
		else if (cmd_done)
		begin
			if (step.data == `FQD_CMD_RESET)
			begin
				autosel_r <= 1'b0;
				query_r   <= 1'b0;
			end
			if (step.data == `FQD_CMD_AUTOSEL)
				autosel_r <= 1'b1;
			if (step.data == `FQD_CMD_QUERY)
				query_r <= 1'b1;
			if (step.data == `FQD_CMD_SUSP)
				susp_r <= 1'b1;
			if (step.data == `FQD_CMD_RESUME)
				susp_r <= 1'b0;
		end
	end

	// Operands; held while busy so a running sequence cannot be disturbed
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			addr_r  <= 20'h0_0000;
			wdata_r <= 16'h0000;
		end
		else if (REG_WR && !busy)
		begin
			if (REG_ADDR == `FQD_REG_ADDR)
				addr_r <= REG_WDATA[19:0];
			if (REG_ADDR == `FQD_REG_WDATA)
				wdata_r <= REG_WDATA[15:0];
		end
	end

	// Result words, indexed by step, and the query check mask
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			qmask_r <= 17'h0_0000;
			for (int k = 0; k < 32; k++)
				res_mem[k] <= 16'h0000;
		end
		else
		begin
			if (start)
				qmask_r <= 17'h0_0000;
			else if (cyc_end && step.kind == fqd_pkg::K_READ && op_r == `FQD_OP_QUERY)
				qmask_r[qidx] <= q_ok(qidx, cyc.rdata);
			if (cyc_end && step.kind != fqd_pkg::K_WRITE)
				res_mem[idx_r] <= cyc.rdata;
		end
	end

	// Register reads answer one cycle later; unmapped offsets read zero
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			REG_RDATA <= 32'h0000_0000;
		else if (!REG_RD)
			REG_RDATA <= 32'h0000_0000;
		else if (REG_ADDR[`FQD_RES_BIT])
			REG_RDATA <= {16'h0000, res_mem[REG_ADDR[6:2]]};
		else
		begin
			case (REG_ADDR)
				`FQD_REG_CTRL:   REG_RDATA <= {28'h000_0000, op_r};
				`FQD_REG_ADDR:   REG_RDATA <= {12'h000, addr_r};
				`FQD_REG_WDATA:  REG_RDATA <= {16'h0000, wdata_r};
				`FQD_REG_STATUS: REG_RDATA <= {24'h00_0000, susp_r, query_r, autosel_r, abt_r, tmo_r,
					(qmask_r == 17'h1_FFFF), done_r, busy};
				`FQD_REG_QMASK:  REG_RDATA <= {15'h0000, qmask_r};
				default:         REG_RDATA <= 32'h0000_0000;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== fqd_flash_model.sv ====
// Flash device model: command decode, identifiers, query table, array.
// Assumes one host on the pins; a program finishes at once.
`timescale 1ns/10ps
`default_nettype none
module fqd_flash_model #(
	parameter logic [7:0] MFR_ID = 8'h3C // Arbitrary code
) (
	// Flash pins
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] din,
	output logic [15:0]      dout
);
	localparam logic [15:0] QT [0:16] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0008,
		16'h0002, 16'h0001, 16'h0001, 16'h0004, 16'h0000, 16'h0000, 16'h0001, 16'h00B5, 16'h00C5, 16'h0005, 16'h0001};
	logic [15:0] mem_r [0:15];
	logic [19:0] lat_a;
	logic [15:0] rd_v;
	logic [1:0]  cyc_r = 2'h0;
	logic [1:0]  mode_r = 2'h0; // Array, ident, query, program armed
	logic [1:0]  fail_r = 2'h0; // Failed program: bit 1 abort, bit 0 timeout
	logic        fdq7_r = 1'b0; // Inverted data bit shown while failed
	initial for (int i = 0; i < 16; i++) mem_r[i] = 16'h0000;
	always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) lat_a = addr;
	always @(posedge we_n or posedge ce_n)
	begin
		if (we_n != ce_n)
		begin
			// Reset leaves any mode or failed program
			if (din[7:0] == 8'hF0)
			begin
				mode_r = 2'h0;
				fail_r = 2'h0;
			end
			else if (mode_r == 2'h3)
			begin
				// Word 0Fh stands in for a buffer overrun; a used word cannot be rewritten
				if (lat_a[3:0] == 4'hF)
					fail_r = 2'h2;
				else if (mem_r[lat_a[3:0]] != 16'h0000)
					fail_r = 2'h1;
				else
					mem_r[lat_a[3:0]] = din;
				fdq7_r = ~din[7];
				mode_r = 2'h0;
			end
			else if (cyc_r == 2'h2)
				mode_r = din[7:0] == 8'h90 ? 2'h1 : din[7:0] == 8'hA0 ? 2'h3 : 2'h0;
			else if (din[7:0] == 8'h98)
				mode_r = 2'h2;
			cyc_r = din[7:0] == 8'hAA ? 2'h1 : (din[7:0] == 8'h55 && cyc_r == 2'h1) ? 2'h2 : 2'h0;
		end
	end
	// No erase runs here, so suspend reads see the whole array
	always_comb
		if (fail_r != 2'h0)
			rd_v = {8'h00, fdq7_r, 1'b0, fail_r[0], 3'b000, fail_r[1], 1'b0}; // Status until a reset
		else
			case (mode_r)
				2'h1: rd_v = addr[7:0] == 8'h02 ? 16'h0001 : {8'h00, MFR_ID ^ addr[7:0]};
				2'h2: rd_v = (addr[7:4] == 4'h4 || addr[7:0] == 8'h50) ? QT[addr[4:0]] : 16'h0000;
				default: rd_v = mem_r[addr[3:0]];
			endcase
	// Released bus shows the inverse, so a stale value never passes
	assign dout = (oe_n || ce_n) ? ~rd_v : rd_v;
endmodule
`default_nettype wire

// ==== fqd_host_ctrl_assertions.sv ====
// Pin-level checks of the host's flash bus cycles.
// Assumes binding to fqd_host_ctrl on one clock.
`timescale 1ns/10ps
`default_nettype none
module fqd_host_ctrl_assertions (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	// Flash pins
	input  wire logic [19:0] FL_ADDR,
	input  wire logic [15:0] FL_DQ_O,
	input  wire logic        FL_DQ_OE_N,
	input  wire logic        FL_CE_N,
	input  wire logic        FL_WE_N,
	input  wire logic        FL_OE_N
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	addr_stable_a: assert property (!FL_WE_N |-> $stable(FL_ADDR) && $stable(FL_DQ_O))
		else $error("address or data moved under write strobe");
	we_in_ce_a: assert property (!FL_WE_N |-> !FL_CE_N && !FL_DQ_OE_N)
		else $error("write strobe outside chip enable");
	no_contend_a: assert property (!FL_OE_N |-> FL_DQ_OE_N && FL_WE_N)
		else $error("read enable while driving");
	we_pulse_a: assert property ($fell(FL_WE_N) |=> FL_WE_N)
		else $error("write strobe not one cycle");
	we_after_ce_a: assert property ($fell(FL_CE_N) && !FL_DQ_OE_N |=> $fell(FL_WE_N))
		else $error("write strobe late");
	ce_after_we_a: assert property ($rose(FL_WE_N) |=> $rose(FL_CE_N) && $rose(FL_DQ_OE_N))
		else $error("chip enable not released after write");
	recovery_a: assert property ($rose(FL_CE_N) |=> FL_CE_N)
		else $error("no recovery cycle");
	read_bound_a: assert property ($fell(FL_OE_N) |-> ##[4:12] $rose(FL_OE_N))
		else $error("read cycle length wrong");
endmodule
bind fqd_host_ctrl fqd_host_ctrl_assertions chk_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .FL_ADDR(FL_ADDR),
	.FL_DQ_O(FL_DQ_O), .FL_DQ_OE_N(FL_DQ_OE_N), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N));
`default_nettype wire

// ==== tb_top.sv ====
// Bench: register tasks drive the host; flash model on the pins.
// Assumes the register map and op codes of fqd_defs.svh.
`timescale 1ns/10ps
`default_nettype none
`include "fqd_defs.svh"
module tb_top;
	localparam logic [7:0] MFR_ID = 8'h3C; // Arbitrary code
	localparam logic [7:0] IDA [0:4] = '{8'h00, 8'h01, 8'h0E, 8'h0F, 8'h03};
	logic        SYS_CLK = 1'b0;
	logic        RESET = 1'b1;
	logic [7:0]  REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0000_0000;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	logic [19:0] FL_ADDR;
	logic [15:0] FL_DQ_O, FL_DQ_I, fl_dout;
	logic        FL_DQ_OE_N, FL_CE_N, FL_WE_N, FL_OE_N;
	int          miscompares = 0;
	int          samples_checked = 0;
	always #50 SYS_CLK = ~SYS_CLK;
	// Wire level: host data while it drives, else the model
	assign FL_DQ_I = FL_DQ_OE_N ? fl_dout : FL_DQ_O;
	fqd_host_ctrl dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O),
		.FL_DQ_OE_N(FL_DQ_OE_N), .FL_DQ_I(FL_DQ_I), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N));
	fqd_flash_model #(.MFR_ID(MFR_ID)) flash_u (.ce_n(FL_CE_N), .we_n(FL_WE_N), .oe_n(FL_OE_N),
		.addr(FL_ADDR), .din(FL_DQ_I), .dout(fl_dout));
	// Compare one word and count it
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Write strobe for one cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
		#1;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1 v = REG_RDATA;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(v & m, e);
	endtask
	// Start an op, then poll busy under a bound
	task automatic go(input logic [3:0] op);
		logic [31:0] v;
		int          n;
		wr(`FQD_REG_CTRL, {28'h000_0000, op});
		repeat (3) @(posedge SYS_CLK);
		v = 32'h0000_0001;
		for (n = 0; n < 3000 && v[0] !== 1'b0; n++) rd(`FQD_REG_STATUS, v);
		chk(v & 32'h0000_0003, 32'h0000_0002);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (20) @(posedge SYS_CLK);
		RESET <= 1'b0;
		@(posedge SYS_CLK);
		#1;
		wr(`FQD_REG_ADDR, 32'h0000_0006);
		go(`FQD_OP_READ);
		rc(8'h80, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(`FQD_REG_WDATA, 32'h0000_1234);
		go(`FQD_OP_PROGRAM);
		go(`FQD_OP_READ);
		rc(8'h80, 32'hFFFF_FFFF, 32'h0000_1234);
		rc(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(`FQD_REG_WDATA, 32'h0000_5678);
		go(`FQD_OP_PROGRAM);
		rc(`FQD_REG_STATUS, 32'h0000_0018, 32'h0000_0008);
		wr(`FQD_REG_ADDR, 32'h0000_000F);
		go(`FQD_OP_PROGRAM);
		rc(`FQD_REG_STATUS, 32'h0000_0018, 32'h0000_0010);
		$display("array test done");
		wr(`FQD_REG_ADDR, 32'h0000_0306);
		go(`FQD_OP_AUTOSEL);
		for (int i = 0; i < 5; i++) rc(8'h8C + 8'(4 * i), 32'hFFFF_FFFF, {24'h00_0000, MFR_ID ^ IDA[i]});
		rc(8'hA0, 32'hFFFF_FFFF, 32'h0000_0001);
		go(`FQD_OP_READ);
		rc(8'h80, 32'hFFFF_FFFF, 32'h0000_1234);
		$display("identifier test done");
		go(`FQD_OP_QUERY);
		rc(`FQD_REG_QMASK, 32'hFFFF_FFFF, 32'h0001_FFFF);
		rc(`FQD_REG_STATUS, 32'h0000_0004, 32'h0000_0004);
		rc(8'hC0, 32'hFFFF_FFFF, 32'h0000_0005);
		rc(8'h84, 32'hFFFF_FFFF, 32'h0000_0050);
		go(`FQD_OP_SUSPEND);
		rc(`FQD_REG_STATUS, 32'h0000_0080, 32'h0000_0080);
		go(`FQD_OP_READ);
		rc(8'h80, 32'hFFFF_FFFF, 32'h0000_1234);
		go(`FQD_OP_RESUME);
		rc(`FQD_REG_STATUS, 32'h0000_0080, 32'h0000_0000);
		$display("query and suspend test done");
		final_report();
	end
	// Watchdog well beyond the expected run
	initial
	begin
		repeat (60000) @(posedge SYS_CLK);
		miscompares++;
		final_report();
	end
endmodule
`default_nettype wire
